// ### rtl/lfr_pkg.sv
/*
  lfr_pkg: register map, field positions and reset values of the
  low-frequency receiver front-end register bank.
  assumes: printed offsets are register indices; byte address = 4 * index.
*/
`default_nettype none
package lfr_pkg;
  localparam int unsigned ADDR_W = 12;
  // register indices
  localparam logic [7:0] IDX_CTRL = 8'h98;
  localparam logic [7:0] IDX_CFG0 = 8'h37;
  localparam logic [7:0] IDX_CFG1 = 8'h38;
  localparam logic [7:0] IDX_CFG2 = 8'haf;
  localparam logic [7:0] IDX_STAT = 8'h39;
  localparam logic [7:0] IDX_MASK = 8'h3a;
  // control register fields
  localparam int CTRL_RECAL = 7;
  localparam int CTRL_AGC_OFF = 6;
  localparam int CTRL_BBM_LO = 4;
  localparam int CTRL_TIMER_EN = 3;
  localparam int CTRL_RX_EN = 2;
  localparam int CTRL_SYNC = 1;
  localparam int CTRL_PWR = 0;
  // config 0 fields
  localparam int CFG0_CDT_LO = 4;
  localparam int CFG0_AGC_THR_LO = 2;
  localparam int CFG0_DIV_LO = 0;
  // config 1 fields
  localparam int CFG1_DECAY_LO = 6;
  localparam int CFG1_ACAL_LO = 4;
  // config 2 fields
  localparam int CFG2_ATK_LO = 0;
  // status / mask bits
  localparam int ST_DECODE_ERR = 0;
  localparam int ST_SYNC = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_W = 3;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CFG0 = 8'h38;
  localparam logic [7:0] RST_CFG1 = 8'h00;
  localparam logic [7:0] RST_CFG2 = 8'h77;
  localparam logic [1:0] DIV_FORBIDDEN = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### rtl/lfr_axil_slave.sv
/*
  lfr_axil_slave: AXI4-Lite slave front end, one write and one read
  at a time, turning bus transfers into single-cycle register strobes.
  assumes: register file answers reads combinationally on rd_addr.
*/
`default_nettype none
module lfr_axil_slave #(
  parameter int unsigned AW = lfr_pkg::ADDR_W
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ok,
  output logic [AW-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held_reg;
  logic w_held_reg;
  logic lane0_reg;
  logic [AW-1:0] awaddr_reg;
  logic [7:0] wdata_reg;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  // only byte lane 0 carries register bits; other lanes are dropped
  assign wr_en = aw_held_reg && w_held_reg && !s_axi_bvalid && lane0_reg;
  assign wr_addr = awaddr_reg;
  assign wr_data = wdata_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
    else if (aw_held_reg && w_held_reg && !s_axi_bvalid)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      lane0_reg <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[7:0];
      lane0_reg <= s_axi_wstrb[0];
    end
    else if (aw_held_reg && w_held_reg && !s_axi_bvalid)
      w_held_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lfr_pkg::RESP_OKAY;
    end
    else if (aw_held_reg && w_held_reg && !s_axi_bvalid)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? lfr_pkg::RESP_OKAY : lfr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lfr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_data};
      s_axi_rresp <= rd_ok ? lfr_pkg::RESP_OKAY : lfr_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ### rtl/lfr_frontend_regs.sv
/*
  lfr_frontend_regs: control, configuration and status registers of the
  low-frequency receiver analog front end, with sync tracking, event
  flags and one level interrupt.
  assumes: decoder and carrier inputs are synchronous one-cycle pulses
  or levels in the aclk domain; the analog side samples the settings.
  bus: AXI4-Lite, one byte-wide register in lane 0 of each word.
  reset: synchronous and active low; one edge is enough.
  limitation: a forbidden divider code is stored but never driven.
*/
// Design decision made here: the AXI4-Lite register port.
// Overview of operation
// - a sync pattern match sets the sync indicator, which stays set while valid data keeps coming.
// - an invalid coded bit clears the sync indicator and sets the decode error flag.
// - the front-end power indicator reads 1 while the front end is powered and 0 while off.
// - the carrier threshold sits in bits 7:4 of config 0, 0000 lowest to 1111 highest, reset 3.
// - divider select bits 1:0 pick factor 1, 6,8 or 22; code 11 is forbidden; reset 0.
// - the AGC threshold is derived from both the AGC threshold and carrier threshold fields.
// - attack time follows the 3-bit field of config 2, decay rate bits 7:6 of config 1.
// - carrier above threshold may wake the device; raw carrier and data go to the baseband.
// - AGC is off while the gain-control-off bit is set and runs while it is clear.
// - gain-control-off is bit 6 of the control register, 0 enables AGC, reset 0.
`default_nettype none
module lfr_frontend_regs #(
  parameter int unsigned AW = lfr_pkg::ADDR_W
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end and decoder
  input wire logic timer_on,
  input wire logic carrier_detect_raw,
  input wire logic demod_raw_out,
  input wire logic sync_match,
  input wire logic manchester_valid,
  input wire logic manchester_invalid,
  // settings to the analog side
  output logic frontend_power_en,
  output logic agc_enable,
  output logic [5:0] agc_threshold_code,
  output logic [2:0] agc_attack_sel,
  output logic [1:0] agc_decay_sel,
  output logic [1:0] autocal_time_sel,
  output logic [3:0] carrier_threshold_level,
  output logic [1:0] input_divider_sel,
  output logic [1:0] baseband_mode,
  output logic recal_start,
  // to baseband and wakeup logic
  output logic bb_carrier_detect,
  output logic bb_demod_data,
  output logic carrier_wakeup,
  output logic irq
);
  localparam logic [AW-1:0] A_CTRL = AW'({lfr_pkg::IDX_CTRL, 2'b00});
  localparam logic [AW-1:0] A_CFG0 = AW'({lfr_pkg::IDX_CFG0, 2'b00});
  localparam logic [AW-1:0] A_CFG1 = AW'({lfr_pkg::IDX_CFG1, 2'b00});
  localparam logic [AW-1:0] A_CFG2 = AW'({lfr_pkg::IDX_CFG2, 2'b00});
  localparam logic [AW-1:0] A_STAT = AW'({lfr_pkg::IDX_STAT, 2'b00});
  localparam logic [AW-1:0] A_MASK = AW'({lfr_pkg::IDX_MASK, 2'b00});

  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_ok;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_ok;

  logic [7:0] ctrl_reg;
  logic [7:0] cfg0_reg;
  logic [7:0] cfg1_reg;
  logic [7:0] cfg2_reg;
  logic [lfr_pkg::ST_W-1:0] status_reg;
  logic [lfr_pkg::ST_W-1:0] status_next;
  logic [lfr_pkg::ST_W-1:0] mask_reg;
  logic [lfr_pkg::ST_W-1:0] events;
  logic sync_reg;
  logic [1:0] div_reg;
  logic wake_seen_reg;

  lfr_axil_slave #(.AW(AW)) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  function automatic logic mapped(input logic [AW-1:0] a);
    mapped = (a == A_CTRL) || (a == A_CFG0) || (a == A_CFG1) ||
             (a == A_CFG2) || (a == A_STAT) || (a == A_MASK);
  endfunction

  // unmapped words answer with an error response, never silence
  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(rd_addr);

  // power follows rx enable; with the timer enabled the timer gates it
  assign frontend_power_en = ctrl_reg[lfr_pkg::CTRL_RX_EN] &&
    (!ctrl_reg[lfr_pkg::CTRL_TIMER_EN] || timer_on);

  // read mux; unmapped words read as zero
  always_comb
  begin
    rd_data = 8'h00;
    if (rd_addr == A_CTRL)
      rd_data = {1'b0, ctrl_reg[6:2], sync_reg,
                 frontend_power_en};
    else if (rd_addr == A_CFG0)
      rd_data = cfg0_reg;
    else if (rd_addr == A_CFG1)
      rd_data = cfg1_reg;
    else if (rd_addr == A_CFG2)
      rd_data = cfg2_reg;
    else if (rd_addr == A_STAT)
      rd_data = 8'(status_reg);
    else if (rd_addr == A_MASK)
      rd_data = 8'(mask_reg);
  end

  // control register; the recal bit self-clears after one cycle
  // bits 1:0 are live views of sync and power, so writes skip them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= lfr_pkg::RST_CTRL;
    else
    begin
      if (wr_en && wr_addr == A_CTRL)
        ctrl_reg <= {wr_data[7:2], 2'b00};
      else
        ctrl_reg[lfr_pkg::CTRL_RECAL] <= 1'b0;
      // a sync wakeup hands power control back to rx enable alone
      if (sync_match)
        ctrl_reg[lfr_pkg::CTRL_TIMER_EN] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg0_reg <= lfr_pkg::RST_CFG0;
    else if (wr_en && wr_addr == A_CFG0)
      cfg0_reg <= wr_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg1_reg <= lfr_pkg::RST_CFG1;
    else if (wr_en && wr_addr == A_CFG1)
      cfg1_reg <= wr_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg2_reg <= lfr_pkg::RST_CFG2;
    else if (wr_en && wr_addr == A_CFG2)
      cfg2_reg <= wr_data;
  end

  // forbidden divider code keeps the last legal setting on the pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_reg <= lfr_pkg::RST_CFG0[lfr_pkg::CFG0_DIV_LO +: 2];
    else if (wr_en && wr_addr == A_CFG0 &&
             wr_data[lfr_pkg::CFG0_DIV_LO +: 2] != lfr_pkg::DIV_FORBIDDEN)
      div_reg <= wr_data[lfr_pkg::CFG0_DIV_LO +: 2];
  end

  // sync: invalid bit or power loss drops it; match wins otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_reg <= 1'b0;
    else if (manchester_invalid || !frontend_power_en)
      sync_reg <= 1'b0;
    else if (sync_match)
      sync_reg <= 1'b1;
    else if (sync_reg && manchester_valid)
      sync_reg <= 1'b1;
  end

  // one wakeup event per rising carrier, not one per cycle
  // a steady carrier would otherwise refill the flag after every clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wake_seen_reg <= 1'b0;
    else
      wake_seen_reg <= carrier_wakeup;
  end

  // events of this cycle, each a one-cycle strobe
  always_comb
  begin
    events = '0;
    events[lfr_pkg::ST_DECODE_ERR] = manchester_invalid;
    events[lfr_pkg::ST_SYNC] = sync_match && frontend_power_en;
    events[lfr_pkg::ST_WAKE] = carrier_wakeup && !wake_seen_reg;
    status_next = status_reg;
    if (wr_en && wr_addr == A_STAT)
      status_next = status_reg & ~wr_data[lfr_pkg::ST_W-1:0];
    // a new event beats a write-one-to-clear in the same cycle
    status_next = status_next | events;
  end

  // write-one-to-clear; a zero bit leaves its pending flag alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  // mask shares the status layout bit for bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= '0;
    else if (wr_en && wr_addr == A_MASK)
      mask_reg <= wr_data[lfr_pkg::ST_W-1:0];
  end

  // level output: high until software clears or masks every set bit
  assign irq = |(status_reg & mask_reg);

  // settings to the analog side, all from flip-flops
  assign agc_enable = !ctrl_reg[lfr_pkg::CTRL_AGC_OFF];
  // both fields together set the gain threshold; neither alone suffices
  assign agc_threshold_code = {cfg0_reg[lfr_pkg::CFG0_CDT_LO +: 4],
    cfg0_reg[lfr_pkg::CFG0_AGC_THR_LO +: 2]};
  assign agc_attack_sel = cfg2_reg[lfr_pkg::CFG2_ATK_LO +: 3];
  assign agc_decay_sel = cfg1_reg[lfr_pkg::CFG1_DECAY_LO +: 2];
  assign autocal_time_sel = cfg1_reg[lfr_pkg::CFG1_ACAL_LO +: 2];
  assign carrier_threshold_level =
    cfg0_reg[lfr_pkg::CFG0_CDT_LO +: 4];
  assign input_divider_sel = div_reg;
  assign baseband_mode = ctrl_reg[lfr_pkg::CTRL_BBM_LO +: 2];
  assign recal_start = ctrl_reg[lfr_pkg::CTRL_RECAL];

  // raw carrier and data registered once on the way to the baseband
  // the extra flop keeps the baseband off the raw input timing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bb_carrier_detect <= 1'b0;
      bb_demod_data <= 1'b0;
    end
    else
    begin
      bb_carrier_detect <= carrier_detect_raw;
      bb_demod_data <= demod_raw_out;
    end
  end

  assign carrier_wakeup = frontend_power_en && bb_carrier_detect;
endmodule
`default_nettype wire

// ### tb/lfr_frontend_monitor.sv
/* lfr_frontend_monitor: port assertions for lfr_frontend_regs.
   assumes writes offer address and data in the same cycle. */
`default_nettype none
module lfr_frontend_monitor #(
  parameter int unsigned AW = 12
)(
  // bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // front end
  input wire logic carrier_detect_raw,
  input wire logic demod_raw_out,
  input wire logic frontend_power_en,
  input wire logic agc_enable,
  input wire logic [5:0] agc_threshold_code,
  input wire logic [2:0] agc_attack_sel,
  input wire logic [1:0] agc_decay_sel,
  input wire logic [3:0] carrier_threshold_level,
  input wire logic [1:0] input_divider_sel,
  input wire logic bb_carrier_detect,
  input wire logic bb_demod_data,
  input wire logic carrier_wakeup
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // register lands one edge after the beat is taken
  sequence s_wr(a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb[0] && s_axi_awaddr == a;
  endsequence
  a_agc_ctrl: assert property (
    s_wr({lfr_pkg::IDX_CTRL, 2'b00}) |->
      ##2 agc_enable == !$past(s_axi_wdata[6], 2))
    else $error("agc enable not taken from control write");
  a_cdt_cfg0: assert property (
    s_wr({lfr_pkg::IDX_CFG0, 2'b00}) |->
      ##2 carrier_threshold_level == $past(s_axi_wdata[7:4], 2))
    else $error("carrier threshold not taken from write");
  a_thr_joint: assert property (
    s_wr({lfr_pkg::IDX_CFG0, 2'b00}) |->
      ##2 agc_threshold_code == $past(s_axi_wdata[7:2], 2))
    else $error("agc threshold code wrong");
  a_div_cfg0: assert property (
    s_wr({lfr_pkg::IDX_CFG0, 2'b00}) ##0 s_axi_wdata[1:0] != 2'h3 |->
      ##2 input_divider_sel == $past(s_axi_wdata[1:0], 2))
    else $error("divider select not taken from write");
  a_div_legal: assert property (
    input_divider_sel != lfr_pkg::DIV_FORBIDDEN)
    else $error("forbidden divider code driven");
  a_decay_cfg1: assert property (
    s_wr({lfr_pkg::IDX_CFG1, 2'b00}) |->
      ##2 agc_decay_sel == $past(s_axi_wdata[7:6], 2))
    else $error("decay select not taken from write");
  a_attack_cfg2: assert property (
    s_wr({lfr_pkg::IDX_CFG2, 2'b00}) |->
      ##2 agc_attack_sel == $past(s_axi_wdata[2:0], 2))
    else $error("attack select not taken from write");
  a_raw_pass: assert property (
    bb_carrier_detect == $past(carrier_detect_raw)
      && bb_demod_data == $past(demod_raw_out))
    else $error("raw carrier or data not passed on");
  a_wake_gate: assert property (
    carrier_wakeup == (frontend_power_en && $past(carrier_detect_raw)))
    else $error("wakeup not gated by power and carrier");
endmodule
bind lfr_frontend_regs lfr_frontend_monitor #(.AW(AW)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .carrier_detect_raw(carrier_detect_raw), .demod_raw_out(demod_raw_out),
  .frontend_power_en(frontend_power_en), .agc_enable(agc_enable),
  .agc_threshold_code(agc_threshold_code),
  .agc_attack_sel(agc_attack_sel), .agc_decay_sel(agc_decay_sel),
  .carrier_threshold_level(carrier_threshold_level),
  .input_divider_sel(input_divider_sel),
  .bb_carrier_detect(bb_carrier_detect), .bb_demod_data(bb_demod_data),
  .carrier_wakeup(carrier_wakeup));
`default_nettype wire

// ### tb/lfr_coil_model.sv
/* lfr_coil_model: antenna, on/off timer and decoder seen from the bank.
   assumes the bench calls its tasks; all outputs move after posedge. */
`default_nettype none
module lfr_coil_model (
  // clock
  input wire logic aclk,
  // toward the bank
  output logic timer_on,
  output logic carrier_detect_raw,
  output logic demod_raw_out,
  output logic sync_match,
  output logic manchester_valid,
  output logic manchester_invalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {timer_on, carrier_detect_raw, demod_raw_out} = 3'h0;
    {sync_match, manchester_valid, manchester_invalid} = 3'h0;
  end
  task automatic timer(input logic on);
    @(posedge aclk);
    timer_on <= on;
  endtask
  task automatic carrier(input logic on);
    @(posedge aclk);
    carrier_detect_raw <= on;
  endtask
  task automatic sync();
    @(posedge aclk);
    sync_match <= 1'b1;
    @(posedge aclk);
    sync_match <= 1'b0;
  endtask
  // data line toggles each bit so a stuck copy shows
  task automatic bits(input int n, input logic bad);
    repeat (n)
    begin
      @(posedge aclk);
      demod_raw_out <= ~demod_raw_out;
      manchester_valid <= !bad;
      manchester_invalid <= bad;
      @(posedge aclk);
      {manchester_valid, manchester_invalid} <= 2'h0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/lfr_frontend_regs_tb.sv
/* lfr_frontend_regs_tb: self-checking bench for the register bank.
   assumes the coil model and monitor are compiled alongside. */
`default_nettype none
module lfr_frontend_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] A_CTRL = {2'b00, lfr_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_CFG0 = {2'b00, lfr_pkg::IDX_CFG0, 2'b00};
  localparam logic [11:0] A_CFG1 = {2'b00, lfr_pkg::IDX_CFG1, 2'b00};
  localparam logic [11:0] A_CFG2 = {2'b00, lfr_pkg::IDX_CFG2, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, lfr_pkg::IDX_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, lfr_pkg::IDX_MASK, 2'b00};
  logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic ton, cdr, dro, sm, mv, mi, pwr, agc, bbc, bbd, wake, irq;
  logic [5:0] thr;
  logic [2:0] atk;
  logic [1:0] dec, acal, div;
  logic [3:0] cdt;
  logic [7:0] d;
  logic [1:0] bbm;
  logic rcl;
  int num_errors = 0, samples_checked = 0, cyc = 0, n_recal = 0;
  lfr_coil_model u_coil (.aclk(aclk), .timer_on(ton),
    .carrier_detect_raw(cdr), .demod_raw_out(dro), .sync_match(sm),
    .manchester_valid(mv), .manchester_invalid(mi));
  lfr_frontend_regs #(.AW(12)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .timer_on(ton),
    .carrier_detect_raw(cdr), .demod_raw_out(dro), .sync_match(sm),
    .manchester_valid(mv), .manchester_invalid(mi),
    .frontend_power_en(pwr), .agc_enable(agc), .agc_threshold_code(thr),
    .agc_attack_sel(atk), .agc_decay_sel(dec), .autocal_time_sel(acal),
    .carrier_threshold_level(cdt), .input_divider_sel(div),
    .baseband_mode(bbm), .recal_start(rcl), .bb_carrier_detect(bbc),
    .bb_demod_data(bbd), .carrier_wakeup(wake), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    @(posedge aclk);
    {awa, wd, ws} <= {a, 24'h0, v, 4'h1};
    {awv, wv, br} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (awr)
        awv <= 1'b0;
      if (wr_)
        wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    {arv, rr} <= 2'b11;
    do
    begin
      @(posedge aclk);
      if (arr)
        arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    chk("rdata_hi", 32'h0, {8'h0, rdat[31:8]});
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    d = rdat[7:0];
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rd(a, lfr_pkg::RESP_OKAY);
    chk("readback", {24'h0, e}, {24'h0, d});
  endtask
  task automatic t_reset();
    rc(A_CTRL, 8'h00);
    rc(A_CFG0, 8'h38);
    rc(A_CFG1, 8'h00);
    rc(A_CFG2, 8'h77);
    rc(A_STAT, 8'h00);
    rc(A_MASK, 8'h00);
    chk("agc_en", 32'h1, {31'h0, agc});
    chk("cdt", 32'h3, {28'h0, cdt});
    chk("thr", 32'h0e, {26'h0, thr});
    chk("div", 32'h0, {30'h0, div});
    $display("test reset done");
  endtask
  task automatic t_cfg();
    // threshold field written 11 as software must
    for (int i = 0; i < 3; i++)
    begin
      wr(A_CFG0, {4'(i * 7), 2'b11, 2'(i)}, lfr_pkg::RESP_OKAY);
      rc(A_CFG0, {4'(i * 7), 2'b11, 2'(i)});
      chk("cdt", 32'(i * 7), {28'h0, cdt});
      chk("div", 32'(i), {30'h0, div});
      chk("thr", {26'h0, 4'(i * 7), 2'b11}, {26'h0, thr});
    end
    wr(A_CFG0, 8'hff, lfr_pkg::RESP_OKAY);
    rc(A_CFG0, 8'hff);
    @(negedge aclk);
    chk("div", 32'h2, {30'h0, div});
    chk("thr", 32'h3f, {26'h0, thr});
    wr(A_CFG1, 8'h20, lfr_pkg::RESP_OKAY);
    rc(A_CFG1, 8'h20);
    chk("acal", 32'h2, {30'h0, acal});
    chk("decay", 32'h0, {30'h0, dec});
    wr(A_CFG1, 8'h10, lfr_pkg::RESP_OKAY);
    chk("acal", 32'h1, {30'h0, acal});
    wr(A_CFG2, 8'h75, lfr_pkg::RESP_OKAY);
    chk("attack", 32'h5, {29'h0, atk});
    wr(12'h004, 8'h55, lfr_pkg::RESP_SLVERR);
    rd(12'h004, lfr_pkg::RESP_SLVERR);
    chk("unmapped", 32'h0, {24'h0, d});
    $display("test config done");
  endtask
  task automatic t_ctrl();
    wr(A_CTRL, 8'h44, lfr_pkg::RESP_OKAY);
    rc(A_CTRL, 8'h45);
    chk("agc_en", 32'h0, {31'h0, agc});
    wr(A_CTRL, 8'h0c, lfr_pkg::RESP_OKAY);
    rc(A_CTRL, 8'h0c);
    u_coil.timer(1'b1);
    rc(A_CTRL, 8'h0d);
    chk("agc_en", 32'h1, {31'h0, agc});
    // recal strobe and baseband mode, then back to timer-gated power
    wr(A_CTRL, 8'h9c, lfr_pkg::RESP_OKAY);
    rc(A_CTRL, 8'h1d);
    chk("bb_mode", 32'h1, {30'h0, bbm});
    chk("recal_now", 32'h0, {31'h0, rcl});
    wr(A_CTRL, 8'h0c, lfr_pkg::RESP_OKAY);
    chk("recal_count", 32'h1, 32'(n_recal));
    $display("test control done");
  endtask
  task automatic t_sync();
    u_coil.sync();
    rc(A_CTRL, 8'h07);
    u_coil.bits(4, 1'b0);
    rc(A_CTRL, 8'h07);
    wr(A_MASK, 8'h01, lfr_pkg::RESP_OKAY);
    u_coil.bits(1, 1'b1);
    rc(A_CTRL, 8'h05);
    rc(A_STAT, 8'h03);
    chk("irq", 32'h1, {31'h0, irq});
    wr(A_STAT, 8'h01, lfr_pkg::RESP_OKAY);
    rc(A_STAT, 8'h02);
    chk("irq", 32'h0, {31'h0, irq});
    u_coil.carrier(1'b1);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("bb_cd", 32'h1, {31'h0, bbc});
    chk("wake", 32'h1, {31'h0, wake});
    rc(A_STAT, 8'h06);
    u_coil.carrier(1'b0);
    $display("test sync done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // recal strobes seen, so a stale bit that fires again shows up
  always @(posedge aclk)
    if (rcl)
      n_recal++;
  // whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      results();
    end
  end
  initial
  begin
    aresetn = 1'b0;
    {awv, wv, br, arv, rr, awa, ara, wd, ws} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cfg();
    t_ctrl();
    t_sync();
    results();
  end
endmodule
`default_nettype wire
